//--- hw/relay_drv.sv
`timescale 1ns/10ps
// Overview of operation
// [R01] Reset low clears shift, control, status registers
// [R02] Pulldowns disabled while reset is low
// [R03] Sample data on serial clock rise while selected
// [R04] Select rising edge copies shift into control
// [R05] Bit 7 drives channel 8, bit 0 channel 1
// [R06] Serial output changes on falling serial clock
// [R07] Select falling edge loads status into shift
// [R08] Outputs hold while select stays low
// [R09] Deselected: ignore clock and data, show first bit
// [R10] Shift register keeps last eight bits only
// [R11] Master deselects after exactly eight bits per device; the testbench also sends one 10-bit frame
// [R12] Filtered fault latches status and raises alert
// [R13] Select rising edge clears latched status
// [R14] Status bit equals command, inverted when faulted
// [R15] Pulldown input gates sources and open-load detection
// [R16] Latch-off enabled: overloaded channel switched off
// [R17] Active channel sinks to ground, else floating
// [R18] Alert pulled low while any fault present
// [R19] Over-temperature forces all channels off
// [R20] Alert latched, released on select rising edge
// [R21] Latched-off channel recovers after new data latched
// [R22] Latch-off disabled: channel stays current-limited
// [R23] Parameterised filter qualifies each raw channel fault
// [R24] Drive is command gated by latch-off, heat, reset
module relay_drv #(
  parameter int FILTER_CYCLES = relay_drv_pkg::FAULT_FILTER_CYCLES
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic RESET_N,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DIN,
  output logic DOUT,
  input wire logic PULLDOWN_DISABLE,
  input wire logic LATCHOFF_DISABLE,
  input wire logic [7:0] OVERLOAD_FAULT,
  input wire logic [7:0] OPEN_LOAD_FAULT,
  input wire logic OVER_TEMP,
  output logic [7:0] SINK_GROUND_EN,
  output logic [7:0] PULLDOWN_EN,
  output logic FLAG_N_O,
  output logic FLAG_N_OE
);
  localparam int CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] FILTER_MAX = CW'(FILTER_CYCLES);

  // Two-stage synchronisers for all pins from outside the clock domain
  logic [1:0] rst_s, cs_s, sclk_s, din_s, pdd_s, lod_s, ot_s;
  logic [7:0] ovl_m, ovl_s, opn_m, opn_s;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rst_s <= 2'h0;
      cs_s <= 2'h3;
      sclk_s <= 2'h0;
      din_s <= 2'h0;
      pdd_s <= 2'h0;
      lod_s <= 2'h0;
      ot_s <= 2'h0;
      ovl_m <= 8'h00;
      ovl_s <= 8'h00;
      opn_m <= 8'h00;
      opn_s <= 8'h00;
    end else begin
      rst_s <= {rst_s[0], RESET_N};
      cs_s <= {cs_s[0], CS_N};
      sclk_s <= {sclk_s[0], SCLK};
      din_s <= {din_s[0], DIN};
      pdd_s <= {pdd_s[0], PULLDOWN_DISABLE};
      lod_s <= {lod_s[0], LATCHOFF_DISABLE};
      ot_s <= {ot_s[0], OVER_TEMP};
      ovl_m <= OVERLOAD_FAULT;
      ovl_s <= ovl_m;
      opn_m <= OPEN_LOAD_FAULT;
      opn_s <= opn_m;
    end
  end

  // Edge detection uses a third, private stage so synchroniser heads stay clean
  logic cs_d, sclk_d;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cs_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_d <= cs_s[1];
      sclk_d <= sclk_s[1];
    end
  end

  logic dev_rst, selected, cs_rise, cs_fall, sclk_rise, sclk_fall;
  assign dev_rst = SRST || !rst_s[1];
  assign selected = !cs_s[1];
  assign cs_rise = cs_s[1] && !cs_d;
  assign cs_fall = !cs_s[1] && cs_d;
  assign sclk_rise = sclk_s[1] && !sclk_d;
  assign sclk_fall = !sclk_s[1] && sclk_d;

  logic [7:0] shift_reg, channel_drive_latch, channel_fault_status, latched_off;
  logic [7:0] fault_now, status_word;
  logic flag_latch;

  // Open-load only counts while pulldowns run
  assign fault_now = ovl_s | (opn_s & {8{!pdd_s[1]}}); // see [R15]

  // Per-channel fault filter counters
  logic [CW-1:0] filt_cnt [8];
  logic [7:0] qualified;
  always_ff @(posedge CLK) begin
    for (int i = 0; i < 8; i++) begin
      if (dev_rst || !fault_now[i]) begin
        filt_cnt[i] <= '0; // see [R23]
      end else if (filt_cnt[i] != FILTER_MAX) begin
        filt_cnt[i] <= filt_cnt[i] + CW'(1);
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      qualified[i] = (filt_cnt[i] == FILTER_MAX); // see [R23]
    end
  end

  // Shift register: status load, sampling, deselected hold
  always_ff @(posedge CLK) begin
    if (dev_rst) begin
      shift_reg <= relay_drv_pkg::DRIVE_RESET; // see [R01]
    end else if (cs_fall) begin
      shift_reg <= status_word; // see [R07]
    end else if (selected && sclk_rise) begin
      shift_reg <= {shift_reg[6:0], din_s[1]}; // see [R03] see [R10]
    end
  end

  // Serial output moves on falling clock and on select fall; first bit shown when idle
  always_ff @(posedge CLK) begin
    if (dev_rst) begin
      DOUT <= 1'b0;
    end else if (!selected || cs_fall || sclk_fall) begin
      DOUT <= cs_fall ? status_word[relay_drv_pkg::MSB_INDEX] : shift_reg[relay_drv_pkg::MSB_INDEX]; // see [R06] see [R09]
    end
  end

  // Command latch changes only on deselect
  always_ff @(posedge CLK) begin
    if (dev_rst) begin
      channel_drive_latch <= relay_drv_pkg::DRIVE_RESET; // see [R01]
    end else if (cs_rise) begin
      channel_drive_latch <= shift_reg; // see [R04] see [R08]
    end
  end

  // Status latch: set wins over the deselect clear
  always_ff @(posedge CLK) begin
    if (dev_rst) begin
      channel_fault_status <= relay_drv_pkg::STATUS_RESET; // see [R01]
    end else begin
      channel_fault_status <= (cs_rise ? 8'h00 : channel_fault_status) | qualified; // see [R12] see [R13]
    end
  end
  assign status_word = channel_drive_latch ^ channel_fault_status; // see [R14] see [R05]

  // Overload latch-off, cleared by new data
  always_ff @(posedge CLK) begin
    if (dev_rst) begin
      latched_off <= 8'h00;
    end else begin
      latched_off <= (cs_rise ? 8'h00 : latched_off) | (ovl_s & qualified & {8{!lod_s[1]}}); // see [R16] see [R21] see [R22]
    end
  end

  // Alert latch; thermal faults bypass the filter
  always_ff @(posedge CLK) begin
    if (dev_rst) begin
      flag_latch <= 1'b0;
    end else begin
      flag_latch <= (cs_rise ? 1'b0 : flag_latch) | (|qualified) | ot_s[1]; // see [R12] see [R20]
    end
  end

  // Drive outputs registered for glitch-free pins
  always_ff @(posedge CLK) begin
    if (dev_rst) begin
      SINK_GROUND_EN <= 8'h00; // see [R01]
      PULLDOWN_EN <= 8'h00; // see [R02]
    end else begin
      SINK_GROUND_EN <= ot_s[1] ? 8'h00 : (channel_drive_latch & ~latched_off); // see [R24] see [R19] see [R17]
      PULLDOWN_EN <= {8{!pdd_s[1]}}; // see [R15]
    end
  end
  assign FLAG_N_O = 1'b0;
  assign FLAG_N_OE = flag_latch; // see [R18]

  // Checks
  cmd_hold_a: assert property (@(posedge CLK) disable iff (dev_rst)
    !cs_rise |=> channel_drive_latch == $past(channel_drive_latch)) else $error("command changed without deselect"); // see [R08]
  cmd_load_a: assert property (@(posedge CLK) disable iff (dev_rst)
    cs_rise |=> channel_drive_latch == $past(shift_reg)) else $error("deselect did not latch word"); // see [R04]
  shift_in_a: assert property (@(posedge CLK) disable iff (dev_rst)
    selected && sclk_rise && !cs_fall |=> shift_reg == {$past(shift_reg[6:0]), $past(din_s[1])})
    else $error("shift failed"); // see [R03]
  idle_hold_a: assert property (@(posedge CLK) disable iff (dev_rst)
    !selected && !cs_fall |=> $stable(shift_reg)) else $error("shift moved while idle"); // see [R09]
  status_load_a: assert property (@(posedge CLK) disable iff (dev_rst)
    cs_fall |=> shift_reg == $past(status_word)) else $error("status not loaded"); // see [R07]
  heat_off_a: assert property (@(posedge CLK) disable iff (dev_rst)
    ot_s[1] |=> SINK_GROUND_EN == 8'h00) else $error("output on during over-temperature"); // see [R19]
  flag_set_a: assert property (@(posedge CLK) disable iff (dev_rst)
    |qualified |=> FLAG_N_OE) else $error("alert missed fault"); // see [R18]
  flag_clear_a: assert property (@(posedge CLK) disable iff (dev_rst)
    cs_rise && !(|qualified) && !ot_s[1] |=> !FLAG_N_OE) else $error("alert not released"); // see [R20]
  latch_off_a: assert property (@(posedge CLK) disable iff (dev_rst)
    (ovl_s & qualified) != 8'h00 && !lod_s[1] ##1 !cs_rise |=> (SINK_GROUND_EN & $past(ovl_s & qualified, 2)) == 8'h00)
    else $error("overload not latched off"); // see [R16]
  reset_pd_a: assert property (@(posedge CLK) !rst_s[1] |=> PULLDOWN_EN == 8'h00 && SINK_GROUND_EN == 8'h00)
    else $error("outputs active in reset"); // see [R02]
endmodule

//--- common/relay_drv_pkg.sv
package relay_drv_pkg;
  localparam int CHANNELS = 8;
  localparam int SYNC_STAGES = 2;
  // Fault filter time in microseconds and its cycle count at the 40 MHz clock
  localparam int FAULT_FILTER_TIME_US = 200;
  localparam int CLK_MHZ = 40;
  localparam int FAULT_FILTER_CYCLES = FAULT_FILTER_TIME_US * CLK_MHZ;
  localparam logic [7:0] DRIVE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int MSB_INDEX = 7;
  localparam int LSB_INDEX = 0;
endpackage

//--- sim/serial_master.sv
`timescale 1ns/10ps
module serial_master (
  input wire logic clk,
  input wire logic dout,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // Idle data keeps toggling so a stale bit never passes for real data
  always @(posedge clk) if (cs_n) din <= ~din;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Clock stands still outside frames except in noise; 4 cycles high and low gives 200 ns
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
    step(1);
    cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      din = tx[i];
      step(4);
      rx = {rx[6:0], dout};
      sclk = 1'b1;
      step(4);
      sclk = 1'b0;
    end
    step(4);
    cs_n = 1'b1;
    step(8);
  endtask
  task automatic noise();
    repeat (4) begin
      sclk = ~sclk;
      step(4);
    end
  endtask
endmodule

//--- sim/tb_relay_drv.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t %0h %0h", $time, g, e); end end
module tb_relay_drv;
  logic clk = 1'b0;
  logic srst, rst_n, pd_dis, lo_dis, hot;
  logic [7:0] ovl, opn;
  logic cs_n, sclk, din, dout, flag, flag_o;
  logic [7:0] sink, pden, rx;
  int n_fail = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  relay_drv #(.FILTER_CYCLES(4)) i_dut (.CLK(clk), .SRST(srst), .RESET_N(rst_n), .CS_N(cs_n), .SCLK(sclk),
    .DIN(din), .DOUT(dout), .PULLDOWN_DISABLE(pd_dis), .LATCHOFF_DISABLE(lo_dis), .OVERLOAD_FAULT(ovl),
    .OPEN_LOAD_FAULT(opn), .OVER_TEMP(hot), .SINK_GROUND_EN(sink), .PULLDOWN_EN(pden), .FLAG_N_O(flag_o),
    .FLAG_N_OE(flag));
  serial_master i_m (.clk(clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));
  task automatic complete_run();
    $display("fails %0d checks %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    rst_n = 1'b1;
    pd_dis = 1'b0;
    lo_dis = 1'b0;
    ovl = 8'h00;
    opn = 8'h00;
    hot = 1'b0;
    i_m.step(2);
    srst = 1'b0;
    i_m.step(6);
    `CHK(sink, 8'h00)
    i_m.xfer(16'h00A5, 8, rx);
    `CHK(sink, 8'hA5)
    `CHK(pden, 8'hFF)
    i_m.xfer(16'h0381, 10, rx);
    `CHK(sink, 8'h81)
    `CHK(dout, 1'b1)
    i_m.noise();
    `CHK(sink, 8'h81)
    pd_dis = 1'b1;
    opn = 8'h10;
    i_m.step(20);
    `CHK(pden, 8'h00)
    `CHK(flag, 1'b0)
    pd_dis = 1'b0;
    i_m.step(20);
    `CHK(flag, 1'b1)
    `CHK(flag_o, 1'b0)
    opn = 8'h00;
    i_m.xfer(16'h0081, 8, rx);
    `CHK(rx, 8'h91)
    `CHK(flag, 1'b0)
    ovl = 8'h01;
    i_m.step(20);
    `CHK(sink, 8'h80)
    ovl = 8'h00;
    i_m.step(10);
    `CHK(sink, 8'h80)
    i_m.xfer(16'h0081, 8, rx);
    `CHK(rx, 8'h80)
    `CHK(sink, 8'h81)
    lo_dis = 1'b1;
    ovl = 8'h80;
    i_m.step(20);
    `CHK(sink, 8'h81)
    ovl = 8'h00;
    i_m.xfer(16'h0081, 8, rx);
    `CHK(rx, 8'h01)
    hot = 1'b1;
    i_m.step(6);
    `CHK(sink, 8'h00)
    `CHK(flag, 1'b1)
    hot = 1'b0;
    rst_n = 1'b0;
    i_m.step(6);
    `CHK(pden, 8'h00)
    `CHK(flag, 1'b0)
    rst_n = 1'b1;
    i_m.step(6);
    i_m.xfer(16'h0042, 8, rx);
    `CHK(rx, 8'h00)
    `CHK(sink, 8'h42)
    complete_run();
  end
  // Whole sequence needs about 610 cycles
  initial begin
    i_m.step(6000);
    n_fail++;
    complete_run();
  end
endmodule
